// file: verilog/interrupt_vector_table_select.sv
// Vector address generator with default and alternate vector table selection.
// Assumes requests, enables and control bits come from logic on clk_i; the core samples the outputs.
//
// How it works
// - With the alternate table enabled, every trap and interrupt vector comes from it.
// - Alternate table used only when configuration bit and run-time enable are both set.
// - No boot segment defined means the default table is always used.
// - Alternate base is the boot segment limit minus one, times 0x800.
// - Alternate table keeps every slot at the same offset as the default table.
// - Reset clears state, loads the fetch address with 000014h and forces the program counter to address zero.
// - Eight trap slots at word addresses 000004h through 000012h, fixed order.
// - Alternate trap slots at base plus 04h to 12h; first two words reserved.
// - Interrupt vector n sits at offset 000014h plus twice n, up to 117.
// - At equal user priority the lower vector number wins; request 0 highest.
// - Flag and enable of request n sit in word n/16, bit n mod 16.
// - Each vector entry is a 24-bit service routine start address.
// - All peripheral requests combine into one request to the core.
// - Seven user levels; ties within a level go by natural priority.
`default_nettype none

module interrupt_vector_table_select (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic alt_table_enable_i,
	input wire logic alt_table_config_bit_i,
	input wire logic boot_segment_defined_i,
	input wire logic [12:0] boot_segment_limit_i,
	input wire logic [127:0] source_request_i,
	input wire logic [127:0] source_flag_clear_i,
	input wire logic [127:0] source_enable_i,
	input wire vector_table_pkg::level_type [127:0] source_level_i,
	input wire vector_table_pkg::level_type cpu_level_i,
	input wire logic [7:0] trap_event_i,
	input wire logic [7:0] trap_clear_i,
	output logic [127:0] pending_flags_o,
	output logic [7:0] trap_flags_o,
	output logic interrupt_request_o,
	output logic vector_is_trap_o,
	output logic [6:0] vector_number_o,
	output logic [23:0] vector_fetch_address_o,
	output logic [23:0] alt_table_base_o,
	output logic alt_table_active_o,
	output logic pc_force_zero_o,
	output logic [23:0] pc_reset_address_o
);

	import vector_table_pkg::*;

	typedef struct packed {
		logic [127:0] pending;
		logic [7:0] traps;
		logic request;
		logic is_trap;
		logic [6:0] number;
		logic [23:0] fetch_address;
		logic [23:0] alt_base;
		logic alt_active;
		logic pc_zero;
	} state_type;

	state_type state;
	state_type next_state;

	logic [127:0] eligible;
	logic [127:0] level_winners;
	logic [2:0] best_level;
	logic source_found;
	logic [6:0] source_index;
	logic trap_found;
	logic [2:0] trap_index;
	logic use_alternate;
	logic [23:0] selected_base;
	logic [12:0] limit_less_one;

	// Offset of a slot inside either table; traps and sources share one layout.
	function automatic address_type slot_offset(input logic is_trap, input logic [6:0] number);
		address_type offset;
		offset = 24'({number, 1'b0});
		if (is_trap) begin
			slot_offset = TRAP_TABLE_OFFSET + offset;
		end else begin
			slot_offset = SOURCE_TABLE_OFFSET + offset;
		end
	endfunction : slot_offset

	// Gathers the sources that may interrupt and the highest level among them.
	always_comb begin
		eligible = state.pending & source_enable_i & SOURCE_IMPLEMENTED;
		best_level = LEVEL_OFF;
		for (int n = 0; n < SLOT_COUNT; n++) begin
			if (eligible[n] && source_level_i[n] > cpu_level_i && source_level_i[n] > best_level) begin
				best_level = source_level_i[n];
			end
		end
		level_winners = '0;
		for (int n = 0; n < SLOT_COUNT; n++) begin
			level_winners[n] = eligible[n] && (best_level != LEVEL_OFF) && (source_level_i[n] == best_level);
		end
	end

	natural_priority_pick #(
		.WIDTH(SLOT_COUNT),
		.INDEX_W(INDEX_WIDTH)
	) source_pick (
		.request_i(level_winners),
		.found_o(source_found),
		.index_o(source_index)
	);

	natural_priority_pick #(
		.WIDTH(TRAP_COUNT),
		.INDEX_W(TRAP_INDEX_WIDTH)
	) trap_pick (
		.request_i(state.traps),
		.found_o(trap_found),
		.index_o(trap_index)
	);

	// Table selection and base address.
	always_comb begin
		use_alternate = alt_table_enable_i && alt_table_config_bit_i && boot_segment_defined_i;
		limit_less_one = boot_segment_limit_i - LIMIT_ONE;
		selected_base = DEFAULT_TABLE_BASE;
		if (use_alternate) begin
			selected_base = 24'(limit_less_one) << PAGE_SHIFT;
		end
	end

	always_comb begin
		next_state = state;
		// A request arriving in the cycle of its clear wins over the clear.
		next_state.pending = ((state.pending & ~source_flag_clear_i) | source_request_i) & SOURCE_IMPLEMENTED;
		next_state.traps = ((state.traps & ~trap_clear_i) | trap_event_i) & TRAP_IMPLEMENTED;
		next_state.alt_active = use_alternate;
		next_state.alt_base = 24'(limit_less_one) << PAGE_SHIFT;
		next_state.pc_zero = 1'b0;
		next_state.request = trap_found || source_found;
		if (trap_found) begin
			next_state.is_trap = 1'b1;
			next_state.number = 7'(trap_index);
		end else if (source_found) begin
			next_state.is_trap = 1'b0;
			next_state.number = source_index;
		end
		next_state.fetch_address = selected_base + slot_offset(next_state.is_trap, next_state.number);
		if (!rstn_i) begin
			next_state = '0;
			next_state.pc_zero = 1'b1;
			next_state.fetch_address = DEFAULT_TABLE_BASE + SOURCE_TABLE_OFFSET;
		end
	end

	always_ff @(posedge clk_i) begin
		state <= next_state;
	end

	assign pending_flags_o = state.pending;
	assign trap_flags_o = state.traps;
	assign interrupt_request_o = state.request;
	assign vector_is_trap_o = state.is_trap;
	assign vector_number_o = state.number;
	assign vector_fetch_address_o = state.fetch_address;
	assign alt_table_base_o = state.alt_base;
	assign alt_table_active_o = state.alt_active;
	assign pc_force_zero_o = state.pc_zero;
	assign pc_reset_address_o = RESET_ADDRESS;

endmodule : interrupt_vector_table_select

`default_nettype wire

// file: verilog/vector_table_pkg.sv
// Constants and types shared by the interrupt vector table selector.
// Assumes a 24-bit program address space and one system clock.
`default_nettype none

package vector_table_pkg;

	localparam int SLOT_COUNT = 128;
	localparam int SOURCE_COUNT = 118;
	localparam int LAST_SOURCE = 117;
	localparam int TRAP_COUNT = 8;
	localparam int FLAG_WORD_WIDTH = 16;
	localparam int FLAG_WORD_COUNT = 8;
	localparam int INDEX_WIDTH = 7;
	localparam int TRAP_INDEX_WIDTH = 3;
	localparam int LIMIT_WIDTH = 13;
	localparam int ADDR_WIDTH = 24;
	localparam int PAGE_SHIFT = 11;

	localparam logic [23:0] RESET_ADDRESS = 24'h000000;
	localparam logic [23:0] PAGE_SIZE = 24'h000800;
	localparam logic [23:0] TRAP_TABLE_OFFSET = 24'h000004;
	localparam logic [23:0] LAST_TRAP_OFFSET = 24'h000012;
	localparam logic [23:0] SOURCE_TABLE_OFFSET = 24'h000014;
	localparam logic [23:0] LAST_SOURCE_OFFSET = 24'h0000fe;
	localparam logic [23:0] DEFAULT_TABLE_BASE = 24'h000000;
	localparam logic [12:0] LIMIT_ONE = 13'h0001;

	// Trap slots 5 and 7 are reserved.
	localparam logic [7:0] TRAP_IMPLEMENTED = 8'h5f;

	// Request numbers with no vector, flag or enable.
	localparam logic [127:0] SOURCE_IMPLEMENTED = ~((128'h1 << 21) | (128'h1 << 34) | (128'h1 << 35) |
		(128'h1 << 52) | (128'h1 << 55) | (128'h1 << 56) | (128'h1 << 57) | (128'h1 << 74) |
		(128'h1 << 75) | (128'h1 << 76) | (128'h1 << 78) | (128'h1 << 79) | (128'h1 << 80) |
		(128'h1 << 92) | (128'h1 << 93) | (128'h3ff << 118));

	localparam logic [2:0] LEVEL_OFF = 3'h0;

	typedef logic [2:0] level_type;
	typedef logic [23:0] address_type;

endpackage : vector_table_pkg

`default_nettype wire

// file: verilog/natural_priority_pick.sv
// Picks the lowest set bit of a request vector: lowest number wins.
// Assumes its inputs come from logic on the same clock; purely combinational.
`default_nettype none

module natural_priority_pick #(
	parameter int WIDTH = 128,
	parameter int INDEX_W = 7
) (
	input wire logic [WIDTH-1:0] request_i,
	output logic found_o,
	output logic [INDEX_W-1:0] index_o
);

	if ((2 ** INDEX_W) < WIDTH || WIDTH < 1) begin : g_check
		$error("natural_priority_pick: index width too small for request width.");
	end

	always_comb begin
		found_o = 1'b0;
		index_o = '0;
		for (int n = WIDTH - 1; n >= 0; n--) begin
			if (request_i[n]) begin
				found_o = 1'b1;
				index_o = INDEX_W'(n);
			end
		end
	end

endmodule : natural_priority_pick

`default_nettype wire

// file: verification/ivts_props.sv
// Port checker for the vector table selector.
// Assumes a bind into interrupt_vector_table_select on one clock.
`default_nettype none
module ivts_props (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic alt_table_enable_i,
	input wire logic alt_table_config_bit_i,
	input wire logic boot_segment_defined_i,
	input wire logic [12:0] boot_segment_limit_i,
	input wire logic [127:0] pending_flags_o,
	input wire logic [7:0] trap_flags_o,
	input wire logic interrupt_request_o,
	input wire logic vector_is_trap_o,
	input wire logic [6:0] vector_number_o,
	input wire logic [23:0] vector_fetch_address_o,
	input wire logic [23:0] alt_table_base_o,
	input wire logic alt_table_active_o,
	input wire logic pc_force_zero_o
);
	import vector_table_pkg::*;
	wire logic want = alt_table_enable_i && alt_table_config_bit_i && boot_segment_defined_i;
	wire logic [23:0] sel = alt_table_active_o ? alt_table_base_o : DEFAULT_TABLE_BASE;
	wire logic [23:0] slot = {16'h0, vector_number_o, 1'b0};
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	property p_active; $past(rstn_i) |-> alt_table_active_o == $past(want); endproperty
	a_active: assert property (p_active) else $error("table select wrong");
	property p_base; $past(rstn_i) |-> alt_table_base_o == {$past(boot_segment_limit_i) - LIMIT_ONE, 11'h0}; endproperty
	a_base: assert property (p_base) else $error("base wrong");
	property p_trap; interrupt_request_o && vector_is_trap_o |-> vector_fetch_address_o == sel + TRAP_TABLE_OFFSET + slot;
	endproperty
	a_trap: assert property (p_trap) else $error("trap address wrong");
	property p_src; interrupt_request_o && !vector_is_trap_o |-> vector_fetch_address_o == sel + SOURCE_TABLE_OFFSET + slot;
	endproperty
	a_src: assert property (p_src) else $error("source address wrong");
	property p_wins; $past(rstn_i) && $past(|trap_flags_o) |-> interrupt_request_o && vector_is_trap_o; endproperty
	a_wins: assert property (p_wins) else $error("trap not presented");
	property p_gaps; (trap_flags_o & ~TRAP_IMPLEMENTED) == 8'h0 && (pending_flags_o & ~SOURCE_IMPLEMENTED) == 128'h0;
	endproperty
	a_gaps: assert property (p_gaps) else $error("unimplemented flag set");
	property p_reset; !$past(rstn_i) |-> pc_force_zero_o && pending_flags_o == 128'h0; endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	property p_run; $past(rstn_i) |-> !pc_force_zero_o; endproperty
	a_run: assert property (p_run) else $error("force zero outside reset");
	c_alt: cover property (alt_table_active_o && interrupt_request_o);
	c_trap: cover property (interrupt_request_o && vector_is_trap_o);
	c_src: cover property (interrupt_request_o && !vector_is_trap_o);
endmodule : ivts_props
bind interrupt_vector_table_select ivts_props i_ivts_props (.*);
`default_nettype wire

// file: verification/vector_core_model.sv
// Core model that takes each presented vector and clears its flag.
// Assumes the selector's registered outputs on the rising clock edge.
`default_nettype none
module vector_core_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic irq_i,
	input wire logic is_trap_i,
	input wire logic [6:0] number_i,
	output var logic [127:0] flag_clear_o,
	output var logic [7:0] trap_clear_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int hold = 0;
	initial {flag_clear_o, trap_clear_o} = '0;
	always @(posedge clk_i) begin
		flag_clear_o <= '0;
		trap_clear_o <= '0;
		hold <= hold > 0 ? hold - 1 : 0;
		if (rstn_i && irq_i && hold == 0) begin
			if (is_trap_i) trap_clear_o[number_i[2:0]] <= 1'b1;
			else flag_clear_o[number_i] <= 1'b1;
			hold <= 3;
		end
	end
endmodule : vector_core_model
`default_nettype wire

// file: verification/interrupt_vector_table_select_bench.sv
// Self-checking bench for the vector table selector.
// Assumes a 50 MHz clock; the core model acknowledges vectors.
`default_nettype none
module interrupt_vector_table_select_bench;
	import vector_table_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rstn = 1'b0, irq, trp, act, pz;
	logic [2:0] s = '0, lv = 3'h1;
	logic [12:0] lim = '0;
	logic [127:0] req = '0, rv, clr, fl;
	logic [7:0] tr = '0, tclr, tf;
	logic [6:0] num;
	logic [23:0] fa, ba, eb, pra;
	int errors = 0, n_checks = 0, seed = 32'h41903f83, last, w, q[$], fix[3] = '{0, 117, 21};
	interrupt_vector_table_select i_interrupt_vector_table_select (.clk_i(clk), .rstn_i(rstn),
		.alt_table_enable_i(s[0]), .alt_table_config_bit_i(s[1]), .boot_segment_defined_i(s[2]),
		.boot_segment_limit_i(lim), .source_request_i(req), .source_flag_clear_i(clr),
		.source_enable_i({128{1'b1}}), .source_level_i({128{lv}}), .cpu_level_i(lv - 3'h1),
		.trap_event_i(tr), .trap_clear_i(tclr), .pending_flags_o(fl), .trap_flags_o(tf),
		.interrupt_request_o(irq), .vector_is_trap_o(trp), .vector_number_o(num),
		.vector_fetch_address_o(fa), .alt_table_base_o(ba), .alt_table_active_o(act),
		.pc_force_zero_o(pz), .pc_reset_address_o(pra));
	vector_core_model i_vector_core_model (.clk_i(clk), .rstn_i(rstn), .irq_i(irq), .is_trap_i(trp),
		.number_i(num), .flag_clear_o(clr), .trap_clear_o(tclr));
	initial forever #10 clk = ~clk;
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task close_out;
		if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	initial begin
		for (int i = 0; i < 14; i++) begin
			if (i % 7 == 0) begin
				rstn = 1'b0;
				repeat (2) @(negedge clk);
				chk(pz, 1'b1);
				chk(fl[23:0], 24'h0);
				chk(pra, 24'h0);
			end
			rstn = 1'b1;
			s = 3'($random(seed));
			lim = 13'($random(seed));
			lv = 3'({$random(seed)} % 7 + 1);
			tr = (i % 3) ? 8'h0 : (i ? 8'($random(seed)) : 8'ha1);
			rv = '0;
			for (int k = 0; k < 3; k++) rv[i ? {$random(seed)} % 128 : fix[k]] = 1'b1;
			req = rv;
			eb = &s ? {lim - 13'h1, 11'h0} : 24'h0;
			q = {};
			for (int t = 0; t < 8; t++) if (tr[t] && TRAP_IMPLEMENTED[t]) q.push_back(128 + t);
			for (int n = 0; n < 128; n++) if (rv[n] && SOURCE_IMPLEMENTED[n]) q.push_back(n);
			@(negedge clk);
			req = '0;
			tr = '0;
			chk(act, &s);
			chk(ba, {lim - 13'h1, 11'h0});
			last = -1;
			foreach (q[j]) begin
				for (w = 0; w < 20 && !(irq === 1'b1 && {trp, num} !== last); w++) @(negedge clk);
				if (w == 20) begin
					errors++;
					close_out();
				end
				chk({trp, num}, 24'(q[j]));
				chk(fa, eb + 24'(q[j] > 127 ? 4 + 2 * (q[j] - 128) : 20 + 2 * q[j]));
				last = q[j];
			end
			repeat (6) @(negedge clk);
			chk(irq, 1'b0);
			chk(tf, 8'h0);
		end
		close_out();
	end
endmodule : interrupt_vector_table_select_bench
`default_nettype wire
